// *** logic/prio_vec_map.svh ***
// register offsets, field layout, reset values for priority/vector regs
`ifndef PRIO_VEC_MAP_SVH
`define PRIO_VEC_MAP_SVH

`define PV_ADDR_W          4
`define PV_OFF_PRIO6       4'h0
`define PV_OFF_PRIO7       4'h1
`define PV_OFF_PRIO8       4'h2
`define PV_OFF_PRIO9       4'h3
`define PV_OFF_PRIO10      4'h4
`define PV_OFF_BASE_UPPER  4'h5
`define PV_OFF_BASE_HIGH   4'h6
`define PV_OFF_BASE_LOW    4'h7
`define PV_OFF_ADDR_UPPER  4'h8
`define PV_OFF_ADDR_HIGH   4'h9
`define PV_OFF_ADDR_LOW    4'ha

`define PV_MASK_PRIO6      8'hff
`define PV_MASK_PRIO7      8'h3b
`define PV_MASK_PRIO8      8'hc0
`define PV_MASK_PRIO9      8'h0f
`define PV_MASK_PRIO10     8'h03
`define PV_MASK_UPPER      8'h1f

`define PV_RST_PRIO6       8'hff
`define PV_RST_PRIO7       8'h3b
`define PV_RST_PRIO8       8'hc0
`define PV_RST_PRIO9       8'h0f
`define PV_RST_PRIO10      8'h00
`define PV_RST_BASE        21'h000008
`define PV_RST_VADDR       21'h000008

`define PV_VEC_IDX_W       8
`define PV_VEC_SHIFT       1

`endif

// *** logic/prio_vec_pkg.sv ***
// types shared by the priority and vector register block
package prio_vec_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] index;
  } vec_req_t;

  typedef enum logic {
    prio_low  = 1'b0,
    prio_high = 1'b1
  } prio_level_t;
endpackage

// *** logic/prio_byte_reg.sv ***
// one 8-bit register with per-bit implemented mask and reset value
`timescale 1ns/1ps
module prio_byte_reg #(
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_value
);
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // unimplemented bits stay zero whatever is written
  always_comb
  begin
    value_next = value_reg;
    if (i_we)
    begin
      value_next = i_wdata & MASK;
    end
  end

  // one reset value for every reset source
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      value_reg <= RESET & MASK;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign o_value = value_reg;
endmodule

// *** logic/prio_vec_regs.sv ***
// interrupt priority registers 6..10 plus vector table base and address
// Function
// - priority 6: eight read/write priority bits
// - priority 7: bits 5,4,3,1,0 implemented
// - priority 8: only bits 7 and 6
// - priority 9: bits 3..0 implemented
// - priority 10: bits 1,0, reset low
// - unimplemented bits read as zero
// - 21-bit base split over three registers
// - base resets to 0x000008
// - read-only 21-bit vector address
// - vector address resets to 0x000008
// - same reset value for every reset
// - lock bit blocks base register writes
`timescale 1ns/1ps
`include "prio_vec_map.svh"
module prio_vec_regs #(
  parameter int VEC_SHIFT = `PV_VEC_SHIFT
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic [`PV_ADDR_W-1:0]     i_addr,
  input  wire logic [7:0]                i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  input  wire logic                      i_table_lock_bit,
  input  wire logic                      i_vec_valid,
  input  wire logic [`PV_VEC_IDX_W-1:0]  i_vec_index,
  output logic      [7:0]                o_rdata,
  output logic      [7:0]                o_prio6,
  output logic      [7:0]                o_prio7,
  output logic      [7:0]                o_prio8,
  output logic      [7:0]                o_prio9,
  output logic      [7:0]                o_prio10,
  output logic      [20:0]               o_vector_base,
  output logic      [20:0]               o_vector_addr
);
  // bus side: a register index on i_addr with a one-cycle write or
  // read strobe; writes land at the strobe edge, and read data are
  // registered, standing only in the cycle after the read strobe and
  // reading zero otherwise, so several slaves can share an or-ed bus
  // dispatch side: the controller pulses i_vec_valid with the vector
  // number; the computed address lands one cycle later and holds
  // limitation: a base write in the same cycle as a dispatch is not
  // seen by that dispatch, which still adds the old base
  // the lock level comes from a lock register kept elsewhere; the
  // sequence that guards it is not handled here
  // unimplemented priority bits never store a one, so the arbiter
  // downstream sees a clean zero in every hole
  prio_vec_pkg::reg_req_t req;
  prio_vec_pkg::vec_req_t vreq;
  logic [7:0]  prio_val [5];
  logic [20:0] base_reg;
  logic [20:0] base_next;
  logic [20:0] vaddr_reg;
  logic [20:0] vaddr_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [20:0] vec_offset;

  // priority selects by source; 1 steers the source to high priority
  typedef prio_vec_pkg::prio_level_t level_t;
  level_t      timer3_gate_prio;
  level_t      timer3_prio;
  level_t      uart2_general_prio;
  level_t      uart2_framing_err_prio;
  level_t      uart2_transmit_prio;
  level_t      uart2_receive_prio;
  level_t      i2c2_error_prio;
  level_t      i2c2_general_prio;
  level_t      ext_irq2_prio;
  level_t      logic_cell2_prio;
  level_t      wavegen2_prio;
  level_t      capcomp2_prio;
  level_t      timer4_prio;
  level_t      timer5_gate_prio;
  level_t      timer5_prio;
  level_t      logic_cell3_prio;
  level_t      wavegen3_prio;
  level_t      capcomp3_prio;
  level_t      timer6_prio;
  level_t      logic_cell4_prio;
  level_t      capcomp4_prio;
  logic [7:0]  prio_view [5];

  // bundle the bus and dispatch inputs
  assign req  = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign vreq = '{valid: i_vec_valid, index: i_vec_index};

  // priority registers, each with its own implemented mask
  prio_byte_reg #(.MASK(`PV_MASK_PRIO6), .RESET(`PV_RST_PRIO6)) u_prio6 (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_we    (req.wr && req.addr == `PV_OFF_PRIO6),
    .i_wdata (req.wdata),
    .o_value (prio_val[0])
  );
  prio_byte_reg #(.MASK(`PV_MASK_PRIO7), .RESET(`PV_RST_PRIO7)) u_prio7 (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_we    (req.wr && req.addr == `PV_OFF_PRIO7),
    .i_wdata (req.wdata),
    .o_value (prio_val[1])
  );
  prio_byte_reg #(.MASK(`PV_MASK_PRIO8), .RESET(`PV_RST_PRIO8)) u_prio8 (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_we    (req.wr && req.addr == `PV_OFF_PRIO8),
    .i_wdata (req.wdata),
    .o_value (prio_val[2])
  );
  prio_byte_reg #(.MASK(`PV_MASK_PRIO9), .RESET(`PV_RST_PRIO9)) u_prio9 (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_we    (req.wr && req.addr == `PV_OFF_PRIO9),
    .i_wdata (req.wdata),
    .o_value (prio_val[3])
  );
  prio_byte_reg #(.MASK(`PV_MASK_PRIO10), .RESET(`PV_RST_PRIO10)) u_prio10 (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_we    (req.wr && req.addr == `PV_OFF_PRIO10),
    .i_wdata (req.wdata),
    .o_value (prio_val[4])
  );

  // name each implemented bit after the source it steers
  assign timer3_gate_prio       = level_t'(prio_val[0][7]);
  assign timer3_prio            = level_t'(prio_val[0][6]);
  assign uart2_general_prio     = level_t'(prio_val[0][5]);
  assign uart2_framing_err_prio = level_t'(prio_val[0][4]);
  assign uart2_transmit_prio    = level_t'(prio_val[0][3]);
  assign uart2_receive_prio     = level_t'(prio_val[0][2]);
  assign i2c2_error_prio        = level_t'(prio_val[0][1]);
  assign i2c2_general_prio      = level_t'(prio_val[0][0]);

  // priority 7 has holes at bits 7, 6 and 2
  assign ext_irq2_prio          = level_t'(prio_val[1][5]);
  assign logic_cell2_prio       = level_t'(prio_val[1][4]);
  assign wavegen2_prio          = level_t'(prio_val[1][3]);
  assign capcomp2_prio          = level_t'(prio_val[1][1]);
  assign timer4_prio            = level_t'(prio_val[1][0]);

  // priority 8 keeps only its two top bits
  assign timer5_gate_prio       = level_t'(prio_val[2][7]);
  assign timer5_prio            = level_t'(prio_val[2][6]);

  // priority 9 keeps only its low nibble
  assign logic_cell3_prio       = level_t'(prio_val[3][3]);
  assign wavegen3_prio          = level_t'(prio_val[3][2]);
  assign capcomp3_prio          = level_t'(prio_val[3][1]);
  assign timer6_prio            = level_t'(prio_val[3][0]);

  // priority 10 bits come out of reset low, unlike the rest
  assign logic_cell4_prio       = level_t'(prio_val[4][1]);
  assign capcomp4_prio          = level_t'(prio_val[4][0]);

  // read views rebuilt from the named selects with the holes tied low;
  // the outputs come straight from the masked registers instead, so a
  // slip in a mask constant shows up as a mismatch between the two
  // paths rather than hiding in both
  assign prio_view[0] = {
    timer3_gate_prio,
    timer3_prio,
    uart2_general_prio,
    uart2_framing_err_prio,
    uart2_transmit_prio,
    uart2_receive_prio,
    i2c2_error_prio,
    i2c2_general_prio
  };

  assign prio_view[1] = {
    2'h0,
    ext_irq2_prio,
    logic_cell2_prio,
    wavegen2_prio,
    1'h0,
    capcomp2_prio,
    timer4_prio
  };

  assign prio_view[2] = {
    timer5_gate_prio,
    timer5_prio,
    6'h00
  };

  assign prio_view[3] = {
    4'h0,
    logic_cell3_prio,
    wavegen3_prio,
    capcomp3_prio,
    timer6_prio
  };

  assign prio_view[4] = {
    6'h00,
    logic_cell4_prio,
    capcomp4_prio
  };

  // base register: writable byte by byte unless the table is locked
  always_comb
  begin
    base_next = base_reg;
    if (req.wr && !i_table_lock_bit)
    begin
      unique case (req.addr)
        `PV_OFF_BASE_UPPER: base_next[20:16] = req.wdata[4:0];
        `PV_OFF_BASE_HIGH:  base_next[15:8]  = req.wdata;
        `PV_OFF_BASE_LOW:   base_next[7:0]   = req.wdata;
        default:            base_next = base_reg;
      endcase
    end
  end

  // word offset of the vector inside the table
  assign vec_offset = 21'(vreq.index) << VEC_SHIFT;

  // address tracks the dispatch; bus writes never reach it
  always_comb
  begin
    vaddr_next = vaddr_reg;
    if (vreq.valid)
    begin
      vaddr_next = base_reg + vec_offset;
    end
  end

  // read mux, registered so data stand one cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        `PV_OFF_PRIO6:      rdata_next = prio_view[0];
        `PV_OFF_PRIO7:      rdata_next = prio_view[1];
        `PV_OFF_PRIO8:      rdata_next = prio_view[2];
        `PV_OFF_PRIO9:      rdata_next = prio_view[3];
        `PV_OFF_PRIO10:     rdata_next = prio_view[4];
        `PV_OFF_BASE_UPPER: rdata_next = {3'h0, base_reg[20:16]};
        `PV_OFF_BASE_HIGH:  rdata_next = base_reg[15:8];
        `PV_OFF_BASE_LOW:   rdata_next = base_reg[7:0];
        `PV_OFF_ADDR_UPPER: rdata_next = {3'h0, vaddr_reg[20:16]};
        `PV_OFF_ADDR_HIGH:  rdata_next = vaddr_reg[15:8];
        `PV_OFF_ADDR_LOW:   rdata_next = vaddr_reg[7:0];
        default:            rdata_next = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // base state; reset value does not depend on reset cause
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      base_reg <= `PV_RST_BASE;
    end
    else
    begin
      base_reg <= base_next;
    end
  end

  // dispatched address state
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vaddr_reg <= `PV_RST_VADDR;
    end
    else
    begin
      vaddr_reg <= vaddr_next;
    end
  end

  // read data state; cleared so an idle bus reads zero
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from the registers
  assign o_rdata       = rdata_reg;
  assign o_prio6       = prio_val[0];
  assign o_prio7       = prio_val[1];
  assign o_prio8       = prio_val[2];
  assign o_prio9       = prio_val[3];
  assign o_prio10      = prio_val[4];
  assign o_vector_base = base_reg;
  assign o_vector_addr = vaddr_reg;
endmodule

// *** bench/prio_vec_assertions.sv ***
// assertion checker for the priority and vector register block
`timescale 1ns/1ps
module prio_vec_checker #(
  parameter int VEC_SHIFT = 1
) (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_table_lock_bit,
  input wire logic        i_vec_valid,
  input wire logic [7:0]  i_vec_index,
  input wire logic [7:0]  o_rdata,
  input wire logic [7:0]  o_prio7,
  input wire logic [7:0]  o_prio8,
  input wire logic [7:0]  o_prio9,
  input wire logic [7:0]  o_prio10,
  input wire logic [20:0] o_vector_base,
  input wire logic [20:0] o_vector_addr
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  logic [20:0] want;
  // address the dispatch should land on, from the base seen now
  assign want = o_vector_base + (21'(i_vec_index) << VEC_SHIFT);
  prio7_gaps_a: assert property ((o_prio7 & 8'hc4) == 8'h00)
    else $error("prio7 gap bit set");
  prio8_gaps_a: assert property ((o_prio8 & 8'h3f) == 8'h00)
    else $error("prio8 gap bit set");
  prio9_gaps_a: assert property (o_prio9[7:4] == 4'h0)
    else $error("prio9 gap bit set");
  prio10_gaps_a: assert property (o_prio10[7:2] == 6'h00)
    else $error("prio10 gap bit set");
  base_lock_a: assert property (i_wr && i_table_lock_bit
    && i_addr inside {4'h5, 4'h6, 4'h7} |=> $stable(o_vector_base))
    else $error("locked base changed");
  base_write_a: assert property (i_wr && !i_table_lock_bit
    && i_addr == 4'h7 |=> o_vector_base[7:0] == $past(i_wdata))
    else $error("base low not written");
  vec_calc_a: assert property (i_vec_valid
    |=> o_vector_addr == $past(want))
    else $error("vector address wrong");
  vec_hold_a: assert property (
    !i_vec_valid |=> $stable(o_vector_addr))
    else $error("vector address moved");
  // a back-to-back read may legally refill the data in the next cycle
  read_back_a: assert property (i_rd && i_addr == 4'h4
    |=> o_rdata == $past(o_prio10)
    ##1 (o_rdata == 8'h00 || $past(i_rd)))
    else $error("prio10 read wrong");
  read_prio7_a: assert property (i_rd && i_addr == 4'h1
    |=> o_rdata == $past(o_prio7))
    else $error("prio7 read wrong");
endmodule

bind prio_vec_regs prio_vec_checker #(.VEC_SHIFT(VEC_SHIFT)) chk_i (.*);

// *** bench/tb_prio_vec_regs.sv ***
// self-checking bench for the priority and vector register block
`timescale 1ns/1ps
module tb_prio_vec_regs;
  logic        i_clock, i_rst_n, i_wr, i_rd, i_table_lock_bit, i_vec_valid;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, i_vec_index, o_rdata;
  logic [7:0]  o_prio6, o_prio7, o_prio8, o_prio9, o_prio10;
  logic [20:0] o_vector_base, o_vector_addr;
  int          bad_count, total_checks;
  logic [7:0]  rv [11] = '{8'hff, 8'h3b, 8'hc0, 8'h0f, 8'h00, 8'h00,
                           8'h00, 8'h08, 8'h00, 8'h00, 8'h08};
  logic [7:0]  mk [5] = '{8'hff, 8'h3b, 8'hc0, 8'h0f, 8'h03};
  logic [7:0]  outs [5];
  // priority outputs by register index
  assign outs = '{o_prio6, o_prio7, o_prio8, o_prio9, o_prio10};
  prio_vec_regs dut (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_table_lock_bit, .i_vec_valid, .i_vec_index, .o_rdata, .o_prio6,
    .o_prio7, .o_prio8, .o_prio9, .o_prio10, .o_vector_base, .o_vector_addr);
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one-cycle write; the trailing step lets the update land
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_clock);
    i_wr <= 1'h0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 chk(21'(o_rdata), 21'(e));
  endtask
  task automatic do_reset();
    i_rst_n <= 1'h0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'h1;
  endtask
  task automatic t_reset_vals();
    for (int k = 0; k < 11; k++)
      rd(4'(k), rv[k]);
    for (int k = 0; k < 5; k++)
      chk(21'(outs[k]), 21'(rv[k]));
    chk(o_vector_base, 21'h000008);
    chk(o_vector_addr, 21'h000008);
  endtask
  // all ones then all zeros: gaps must stay clear
  task automatic t_prio_masks();
    for (int k = 0; k < 5; k++)
    begin
      wr(4'(k), 8'hff);
      chk(21'(outs[k]), 21'(mk[k]));
      rd(4'(k), mk[k]);
      wr(4'(k), 8'h00);
      rd(4'(k), 8'h00);
    end
    rd(4'hf, 8'h00);
  endtask
  task automatic t_base();
    wr(4'h5, 8'hff);
    wr(4'h6, 8'ha5);
    wr(4'h7, 8'h3c);
    rd(4'h5, 8'h1f);
    chk(o_vector_base, 21'h1fa53c);
    @(posedge i_clock);
    i_table_lock_bit <= 1'h1;
    wr(4'h7, 8'h00);
    wr(4'h5, 8'h00);
    chk(o_vector_base, 21'h1fa53c);
    @(posedge i_clock);
    i_table_lock_bit <= 1'h0;
    wr(4'h7, 8'h10);
    chk(o_vector_base, 21'h1fa510);
  endtask
  // top index forces a carry out of the low byte
  task automatic t_vector();
    wr(4'h8, 8'hff);
    wr(4'ha, 8'hff);
    chk(o_vector_addr, 21'h000008);
    @(posedge i_clock);
    i_vec_index <= 8'hff;
    i_vec_valid <= 1'h1;
    @(posedge i_clock);
    i_vec_valid <= 1'h0;
    #1 chk(o_vector_addr, 21'h1fa510 + (21'h0000ff << 1));
    rd(4'h8, 8'h1f);
    rd(4'h9, 8'ha7);
    rd(4'ha, 8'h0e);
  endtask
  task automatic close_out();
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    i_clock = 1'h0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial
  begin
    {i_wr, i_rd, i_table_lock_bit, i_vec_valid} <= 4'h0;
    {i_addr, i_wdata, i_vec_index} <= 20'h00000;
    do_reset();
    t_reset_vals();
    t_prio_masks();
    t_base();
    t_vector();
    do_reset();
    t_reset_vals();
    close_out();
  end
endmodule
